// >>> core/stepper_ramp_cfg.svh
// constants for the linear ramp stepper controller
`ifndef STEPPER_RAMP_CFG_SVH
`define STEPPER_RAMP_CFG_SVH

// system clock and step timer rate in Hz
`define CLOCK_HZ              100000000
`define TIMER_HZ              1000000
`define TICK_CYCLES           (`CLOCK_HZ / `TIMER_HZ)

// precomputed for 200 steps per round at the timer rate above
// step angle * timer rate * 100
`define ANGLE_FREQ_PRODUCT    40'h00002FEFD9
// 0.676 * timer rate / 100
`define SCALED_TIMER_CONSTANT 32'h00001A68
// 2 * step angle * 1e10
`define DOUBLED_ANGLE_SCALED  40'h0025736143
// 2 * step angle * 100 * 100
`define ANGLE_X20000          40'h0000000274
`define SCALE_100             40'h0000000064

// period used for a single-step move, in timer ticks
`define ONE_STEP_DELAY        32'h000003E8

// profile field widths
`define STEPS_W               17
`define RATE_W                16

`endif

// >>> core/stepper_ramp_pkg.sv
// types shared by the linear ramp stepper controller
package stepper_ramp_pkg;

    typedef enum logic [1:0] {
        MOTION_STOP,
        MOTION_ACCEL,
        MOTION_RUN,
        MOTION_DECEL
    } motion_state_t;

    typedef enum logic [3:0] {
        SET_IDLE,
        SET_CRUISE,
        SET_ROOTARG,
        SET_ROOT,
        SET_FIRST,
        SET_RAMPDEN,
        SET_MAXLIM,
        SET_ACCLIM,
        SET_DECVAL,
        SET_LAUNCH,
        SET_GO
    } setup_phase_t;

    typedef struct packed {
        logic signed [16:0] steps;
        logic [15:0]        accel;
        logic [15:0]        decel;
        logic [15:0]        speed;
    } profile_t;

    typedef struct packed {
        logic       pulse;
        logic       dirReverse;
        logic [2:0] phaseIdx;
        logic [3:0] coils;
    } drive_t;

endpackage

// >>> core/seq_divider.sv
// iterative restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
module seq_divider #(
    parameter int W = 40
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    output logic              done,
    output logic [W-1:0]      quotient,
    output logic [W-1:0]      remainder
);

    localparam int CW = $clog2(W + 1);

    logic [W-1:0]  quoReg;
    logic [W-1:0]  remReg;
    logic [W-1:0]  denReg;
    logic [CW-1:0] cntReg;
    logic          busyReg;
    logic          doneReg;
    logic [W:0]    trial;
    logic [W:0]    diff;

    assign trial = {remReg, quoReg[W-1]};
    assign diff  = trial - {1'b0, denReg};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            quoReg  <= '0;
            remReg  <= '0;
            denReg  <= '0;
            cntReg  <= '0;
            busyReg <= 1'b0;
            doneReg <= 1'b0;
        end else begin
            doneReg <= 1'b0;
            if (start && !busyReg) begin
                quoReg  <= dividend;
                remReg  <= '0;
                denReg  <= divisor;
                cntReg  <= CW'(W);
                busyReg <= 1'b1;
            end else if (busyReg) begin
                // zero divisor yields an all-ones quotient
                if (!diff[W]) begin
                    remReg <= diff[W-1:0];
                    quoReg <= {quoReg[W-2:0], 1'b1};
                end else begin
                    remReg <= trial[W-1:0];
                    quoReg <= {quoReg[W-2:0], 1'b0};
                end
                cntReg <= cntReg - 1'b1;
                if (cntReg == CW'(1)) begin
                    busyReg <= 1'b0;
                    doneReg <= 1'b1;
                end
            end
        end
    end

    assign done      = doneReg;
    assign quotient  = quoReg;
    assign remainder = remReg;

endmodule // seq_divider

// >>> core/stepper_linear_ramp_controller.sv
// linear speed ramp stepper controller: setup math, ramp engine, step timer, phase drive
`timescale 1ns/1ps
`include "stepper_ramp_cfg.svh"
module stepper_linear_ramp_controller
    import stepper_ramp_pkg::*;
#(
    parameter int DIV_W       = 40,
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                moveStart,
    input  wire profile_t            profile,
    input  wire logic                halfStep,
    output logic                     moveBusy,
    output motion_state_t            motionState,
    output drive_t                   drive,
    output logic signed [31:0]       position,
    output logic [`STEPS_W-1:0]      stepCount
);

    ////////////////////////////////////////////////////////////////////
    // state

    profile_t             cmdReg;
    setup_phase_t         phaseReg;
    motion_state_t        stateReg;
    motion_state_t        goStateReg;
    logic                 divWaitReg;
    logic                 rampPendReg;
    logic                 dirReg;
    logic [`STEPS_W-1:0]  stepsAbsReg;
    logic [`STEPS_W-1:0]  stepCountReg;
    logic [`STEPS_W-1:0]  decelStartReg;
    logic [31:0]          minDelayReg;
    logic [31:0]          stepDelayReg;
    logic [31:0]          lastAccelReg;
    logic [31:0]          restReg;
    logic [DIV_W-1:0]     tmpReg;
    logic [DIV_W-1:0]     maxLimReg;
    logic [DIV_W-1:0]     accelLimReg;
    logic signed [31:0]   decelValReg;
    logic signed [31:0]   accelCountReg;
    logic [15:0]          rootReg;
    logic [3:0]           rootBitReg;
    logic [31:0]          periodLenReg;
    logic [31:0]          periodCntReg;
    logic [15:0]          tickCntReg;
    logic [2:0]           phaseIdxReg;
    logic [3:0]           coilsReg;
    logic                 pulseReg;
    logic signed [31:0]   positionReg;

    logic                 stepEvt;
    logic                 rampStart;
    logic                 setupDiv;
    logic                 divStart;
    logic                 divDone;
    logic [DIV_W-1:0]     divNum;
    logic [DIV_W-1:0]     divDen;
    logic [DIV_W-1:0]     divQuo;
    logic [DIV_W-1:0]     divRem;
    logic signed [31:0]   rampDenS;
    logic [31:0]          newDelay;
    logic [15:0]          rootTrial;
    logic [31:0]          rootSq;
    logic [DIV_W-1:0]     decelMag;
    logic [`STEPS_W-1:0]  startAbs;
    logic [2:0]           patIdx;

    ////////////////////////////////////////////////////////////////////
    // shared divider

    assign startAbs  = profile.steps[16] ? `STEPS_W'(-profile.steps) : `STEPS_W'(profile.steps);
    assign rampStart = stepEvt && (stateReg == MOTION_ACCEL || stateReg == MOTION_DECEL);
    assign setupDiv  = phaseReg inside {SET_CRUISE, SET_ROOTARG, SET_FIRST, SET_RAMPDEN,
                                        SET_MAXLIM, SET_ACCLIM, SET_DECVAL};
    assign divStart  = rampStart || (setupDiv && !divWaitReg);

    // denominator 4n+1 uses the index after this step's increment
    assign rampDenS  = 32'(((accelCountReg + 32'sd1) <<< 2) + 32'sd1);

    always_comb begin
        divNum = '0;
        divDen = '0;
        if (rampStart) begin
            divNum = DIV_W'({stepDelayReg, 1'b0}) + DIV_W'(restReg);
            divDen = rampDenS[31] ? DIV_W'(-rampDenS) : DIV_W'(rampDenS);
        end else begin
            case (phaseReg)
                SET_CRUISE: begin
                    divNum = `ANGLE_FREQ_PRODUCT;
                    divDen = DIV_W'(cmdReg.speed);
                end
                SET_ROOTARG: begin
                    divNum = `DOUBLED_ANGLE_SCALED;
                    divDen = DIV_W'(cmdReg.accel);
                end
                SET_FIRST: begin
                    divNum = DIV_W'(`SCALED_TIMER_CONSTANT * 32'(rootReg));
                    divDen = `SCALE_100;
                end
                SET_RAMPDEN: begin
                    divNum = `ANGLE_X20000 * DIV_W'(cmdReg.accel);
                    divDen = `SCALE_100;
                end
                SET_MAXLIM: begin
                    divNum = DIV_W'(cmdReg.speed) * DIV_W'(cmdReg.speed);
                    divDen = tmpReg;
                end
                SET_ACCLIM: begin
                    divNum = DIV_W'(stepsAbsReg) * DIV_W'(cmdReg.decel);
                    divDen = DIV_W'(cmdReg.accel) + DIV_W'(cmdReg.decel);
                end
                SET_DECVAL: begin
                    divNum = maxLimReg * DIV_W'(cmdReg.accel);
                    divDen = DIV_W'(cmdReg.decel);
                end
                default: begin
                    divNum = '0;
                    divDen = '0;
                end
            endcase
        end
    end

    seq_divider #(
        .W (DIV_W)
    ) u_div (
        .clock     (clock),
        .rst_n     (rst_n),
        .start     (divStart),
        .dividend  (divNum),
        .divisor   (divDen),
        .done      (divDone),
        .quotient  (divQuo),
        .remainder (divRem)
    );

    // negative index lengthens the period, positive shortens it
    assign newDelay  = accelCountReg[31] ? stepDelayReg + divQuo[31:0] : stepDelayReg - divQuo[31:0];
    assign rootTrial = rootReg | (16'h0001 << rootBitReg);
    assign rootSq    = 32'(rootTrial) * 32'(rootTrial);
    assign decelMag  = (maxLimReg < accelLimReg) ? divQuo : DIV_W'(stepsAbsReg) - accelLimReg;

    ////////////////////////////////////////////////////////////////////
    // setup sequencer and ramp engine

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmdReg        <= '0;
            phaseReg      <= SET_IDLE;
            stateReg      <= MOTION_STOP;
            goStateReg    <= MOTION_STOP;
            divWaitReg    <= 1'b0;
            rampPendReg   <= 1'b0;
            dirReg        <= 1'b0;
            stepsAbsReg   <= '0;
            stepCountReg  <= '0;
            decelStartReg <= '0;
            minDelayReg   <= '0;
            stepDelayReg  <= '0;
            lastAccelReg  <= '0;
            restReg       <= '0;
            tmpReg        <= '0;
            maxLimReg     <= '0;
            accelLimReg   <= '0;
            decelValReg   <= '0;
            accelCountReg <= '0;
            rootReg       <= '0;
            rootBitReg    <= '0;
        end else begin
            if (divStart && !rampStart) begin
                divWaitReg <= 1'b1;
            end
            case (phaseReg)
                SET_IDLE: begin
                    if (moveStart && stateReg == MOTION_STOP && profile.steps != '0) begin
                        cmdReg       <= profile;
                        dirReg       <= profile.steps[16];
                        stepsAbsReg  <= startAbs;
                        stepCountReg <= '0;
                        restReg      <= '0;
                        if (startAbs == `STEPS_W'(1)) begin
                            // single step goes straight to decel
                            accelCountReg <= -32'sd1;
                            stepDelayReg  <= `ONE_STEP_DELAY;
                            goStateReg    <= MOTION_DECEL;
                            phaseReg      <= SET_GO;
                        end else begin
                            phaseReg <= SET_CRUISE;
                        end
                    end
                end
                SET_ROOT: begin
                    if (DIV_W'(rootSq) <= tmpReg) begin
                        rootReg <= rootTrial;
                    end
                    rootBitReg <= rootBitReg - 1'b1;
                    if (rootBitReg == 4'h0) begin
                        phaseReg <= SET_FIRST;
                    end
                end
                SET_LAUNCH: begin
                    // ramp data stored before timer enable
                    decelStartReg <= `STEPS_W'(32'(stepsAbsReg) + decelValReg);
                    accelCountReg <= '0;
                    stepCountReg  <= '0;
                    restReg       <= '0;
                    lastAccelReg  <= minDelayReg;
                    if (stepDelayReg <= minDelayReg) begin
                        stepDelayReg <= minDelayReg;
                        goStateReg   <= MOTION_RUN;
                    end else begin
                        goStateReg <= MOTION_ACCEL;
                    end
                    phaseReg <= SET_GO;
                end
                SET_GO: begin
                    stateReg <= goStateReg;
                    phaseReg <= SET_IDLE;
                end
                default: begin
                    if (divDone && divWaitReg) begin
                        divWaitReg <= 1'b0;
                        phaseReg   <= phaseReg.next();
                        case (phaseReg)
                            SET_CRUISE:  minDelayReg <= divQuo[31:0];
                            SET_ROOTARG: begin
                                tmpReg     <= divQuo;
                                rootReg    <= '0;
                                rootBitReg <= 4'hF;
                            end
                            SET_FIRST:   stepDelayReg <= divQuo[31:0];
                            SET_RAMPDEN: tmpReg <= divQuo;
                            SET_MAXLIM:  maxLimReg <= (divQuo == '0) ? DIV_W'(1) : divQuo;
                            SET_ACCLIM:  accelLimReg <= (divQuo == '0) ? DIV_W'(1) : divQuo;
                            SET_DECVAL:  decelValReg <= (decelMag == '0) ? -32'sd1 : -$signed(decelMag[31:0]);
                            default: ;
                        endcase
                    end
                end
            endcase

            if (stepEvt) begin
                stepCountReg <= stepCountReg + 1'b1;
                case (stateReg)
                    MOTION_ACCEL, MOTION_DECEL: begin
                        accelCountReg <= accelCountReg + 32'sd1;
                        rampPendReg   <= 1'b1;
                    end
                    MOTION_RUN: begin
                        if (stepCountReg + 1'b1 >= decelStartReg) begin
                            accelCountReg <= decelValReg;
                            stepDelayReg  <= lastAccelReg;
                            stateReg      <= MOTION_DECEL;
                        end
                    end
                    default: ;
                endcase
            end else if (rampPendReg && divDone) begin
                rampPendReg  <= 1'b0;
                stepDelayReg <= newDelay;
                restReg      <= divRem[31:0];
                if (stateReg == MOTION_DECEL) begin
                    if (!accelCountReg[31]) begin
                        stateReg <= MOTION_STOP;
                    end
                end else if (stepCountReg >= decelStartReg) begin
                    accelCountReg <= decelValReg;
                    stateReg      <= MOTION_DECEL;
                end else if (newDelay <= minDelayReg) begin
                    lastAccelReg <= newDelay;
                    stepDelayReg <= minDelayReg;
                    restReg      <= '0;
                    stateReg     <= MOTION_RUN;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // step period timer

    assign stepEvt = (stateReg != MOTION_STOP) && (tickCntReg == 16'(TICK_CYCLES - 1))
                     && (periodCntReg + 32'h1 >= periodLenReg);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tickCntReg   <= '0;
            periodCntReg <= '0;
            periodLenReg <= '0;
        end else if (stateReg == MOTION_STOP) begin
            tickCntReg   <= '0;
            periodCntReg <= '0;
            periodLenReg <= stepDelayReg;
        end else if (tickCntReg == 16'(TICK_CYCLES - 1)) begin
            tickCntReg <= '0;
            if (stepEvt) begin
                periodCntReg <= '0;
                periodLenReg <= stepDelayReg;
            end else begin
                periodCntReg <= periodCntReg + 32'h1;
            end
        end else begin
            tickCntReg <= tickCntReg + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // phase index, position and coil drive

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phaseIdxReg <= '0;
            positionReg <= '0;
            pulseReg    <= 1'b0;
        end else begin
            pulseReg <= stepEvt;
            if (stepEvt) begin
                // wrap over four or eight positions
                if (dirReg) begin
                    phaseIdxReg <= halfStep ? phaseIdxReg - 3'h1 : {1'b0, phaseIdxReg[1:0] - 2'h1};
                    positionReg <= positionReg - 32'sd1;
                end else begin
                    phaseIdxReg <= halfStep ? phaseIdxReg + 3'h1 : {1'b0, phaseIdxReg[1:0] + 2'h1};
                    positionReg <= positionReg + 32'sd1;
                end
            end
        end
    end

    assign patIdx = halfStep ? phaseIdxReg : {phaseIdxReg[1:0], 1'b0};

    // coils are {a forward, a reverse, b forward, b reverse}
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            coilsReg <= '0;
        end else begin
            case (patIdx)
                3'h0:    coilsReg <= 4'h8;
                3'h1:    coilsReg <= 4'hA;
                3'h2:    coilsReg <= 4'h2;
                3'h3:    coilsReg <= 4'h6;
                3'h4:    coilsReg <= 4'h4;
                3'h5:    coilsReg <= 4'h5;
                3'h6:    coilsReg <= 4'h1;
                3'h7:    coilsReg <= 4'h9;
                default: coilsReg <= 4'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign moveBusy         = (phaseReg != SET_IDLE) || (stateReg != MOTION_STOP);
    assign motionState      = stateReg;
    assign drive.pulse      = pulseReg;
    assign drive.dirReverse = dirReg;
    assign drive.phaseIdx   = phaseIdxReg;
    assign drive.coils      = coilsReg;
    assign position         = positionReg;
    assign stepCount        = stepCountReg;

endmodule // stepper_linear_ramp_controller

// >>> dv/step_ramp_checker_assertions.sv
// assertion checker for the linear ramp stepper controller
`timescale 1ns/1ps
module step_ramp_checker
    import stepper_ramp_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               moveStart,
    input  wire profile_t           profile,
    input  wire logic               halfStep,
    input  wire logic               moveBusy,
    input  wire motion_state_t      motionState,
    input  wire drive_t             drive,
    input  wire logic signed [31:0] position,
    input  wire logic [16:0]        stepCount
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic       taken;
    logic [2:0] mask;
    assign taken = moveStart && !moveBusy && (profile.steps != 17'sh0);
    assign mask = halfStep ? 3'h7 : 3'h3;
    ////////////////////////////////////////////////////////////////
    property p_take; taken |=> moveBusy; endproperty
    a_take: assert property (p_take) else $error("start not taken");
    property p_go; taken |-> ##[1:400] (motionState != MOTION_STOP && stepCount == 17'h0); endproperty
    a_go: assert property (p_go) else $error("motion did not begin cleared");
    property p_pulse; drive.pulse |=> !drive.pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse longer than one cycle");
    property p_pos; drive.pulse |-> position == (drive.dirReverse ? $past(position) - 32'sh1 : $past(position) + 32'sh1);
    endproperty
    a_pos: assert property (p_pos) else $error("position not moved by one");
    property p_cnt; drive.pulse |-> stepCount == $past(stepCount) + 17'h1; endproperty
    a_cnt: assert property (p_cnt) else $error("step count not advanced");
    property p_idle; !moveBusy && !$past(moveBusy) |-> $stable(position) && !drive.pulse; endproperty
    a_idle: assert property (p_idle) else $error("step while idle");
    property p_dir; taken |=> drive.dirReverse == $past(profile.steps[16]); endproperty
    a_dir: assert property (p_dir) else $error("direction not from sign");
    property p_dirhold; moveBusy && $past(moveBusy) |-> $stable(drive.dirReverse); endproperty
    a_dirhold: assert property (p_dirhold) else $error("direction changed in move");
    property p_phase; drive.pulse |-> ((drive.phaseIdx - $past(drive.phaseIdx)) & mask) == (drive.dirReverse ? mask : 3'h1);
    endproperty
    a_phase: assert property (p_phase) else $error("phase index step wrong");
    property p_busy; $fell(moveBusy) |-> motionState == MOTION_STOP && $past(motionState) == MOTION_DECEL;
    endproperty
    a_busy: assert property (p_busy) else $error("move did not end from decel");
    property p_decel; $past(motionState) == MOTION_DECEL |-> motionState inside {MOTION_DECEL, MOTION_STOP}; endproperty
    a_decel: assert property (p_decel) else $error("bad exit from decel");
    property p_run; $past(motionState) == MOTION_RUN |-> motionState inside {MOTION_RUN, MOTION_DECEL}; endproperty
    a_run: assert property (p_run) else $error("bad exit from run");
    c_run: cover property (motionState == MOTION_RUN);
    c_half: cover property (drive.pulse && halfStep);
    c_rev: cover property (drive.pulse && drive.dirReverse);
endmodule // step_ramp_checker

bind stepper_linear_ramp_controller step_ramp_checker u_chk (.clock(clock), .rst_n(rst_n), .moveStart(moveStart),
    .profile(profile), .halfStep(halfStep), .moveBusy(moveBusy), .motionState(motionState), .drive(drive),
    .position(position), .stepCount(stepCount));

// >>> dv/phase_driver_model.sv
// step pulse receiver standing in for the motor phase driver
`timescale 1ns/1ps
module phase_driver_model
    import stepper_ramp_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rst_n,
    input  wire drive_t drive,
    output int          pulseTotal,
    output int          gapShort
);
    int gap;
    ////////////////////////////////////////////////////////////////
    // count pulses, flag spacing too short
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulseTotal <= 0;
            gapShort <= 0;
            gap <= 1000;
        end else if (drive.pulse) begin
            pulseTotal <= pulseTotal + 1;
            gapShort <= gapShort + ((gap < 42) ? 1 : 0);
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
    end
endmodule // phase_driver_model

// >>> dv/tb.sv
// self-checking bench for the linear ramp stepper controller
`timescale 1ns/1ps
`include "stepper_ramp_cfg.svh"
module tb;
    import stepper_ramp_pkg::*;
    logic               clock, rst_n, moveStart, halfStep, moveBusy;
    profile_t           profile;
    motion_state_t      motionState;
    drive_t             drive;
    logic signed [31:0] position, expPos;
    logic [16:0]        stepCount;
    logic [31:0]        seed, r;
    int                 pulseTotal, gapShort, n_mismatch, checked;
    stepper_linear_ramp_controller #(.TICK_CYCLES(1)) DUT (.clock(clock), .rst_n(rst_n), .moveStart(moveStart),
        .profile(profile), .halfStep(halfStep), .moveBusy(moveBusy), .motionState(motionState), .drive(drive),
        .position(position), .stepCount(stepCount));
    phase_driver_model u_drv (.clock(clock), .rst_n(rst_n), .drive(drive), .pulseTotal(pulseTotal),
        .gapShort(gapShort));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [16:0] mag(input logic signed [16:0] s);
        return (s < 0) ? 17'(-s) : 17'(s);
    endfunction
    // winding pattern {a forward, a reverse, b forward, b reverse}; full step uses every other entry
    function automatic logic [3:0] coil_pat(input logic [2:0] p, input logic h);
        logic [31:0] tbl;
        logic [2:0]  i;
        tbl = 32'h915462A8;
        i = h ? p : {p[1:0], 1'b0};
        return tbl[4*i +: 4];
    endfunction
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // a second start while busy must be ignored
    task automatic do_move(input logic signed [16:0] st, input logic [15:0] ac, input logic [15:0] sp,
                           input logic hs, input logic expRun);
        int            n0, cyc, t0, lead;
        logic          sawRun;
        motion_state_t first;
        n0 = pulseTotal;
        cyc = 0;
        lead = -1;
        sawRun = 0;
        first = MOTION_STOP;
        halfStep = hs;
        profile = '{st, ac, ac, sp};
        moveStart = 1'b1;
        @(negedge clock);
        profile.steps = -st;
        check(moveBusy, 1'b1);
        check(drive.dirReverse, st < 0);
        @(negedge clock);
        moveStart = 1'b0;
        while (moveBusy === 1'b1 && cyc < 50000) begin
            if (first == MOTION_STOP && motionState != MOTION_STOP) begin
                first = motionState;
                t0 = cyc;
            end
            if (motionState == MOTION_RUN) sawRun = 1'b1;
            if (lead < 0 && drive.pulse === 1'b1) lead = cyc - t0;
            cyc++;
            @(negedge clock);
        end
        if (cyc >= 50000) begin
            n_mismatch++;
            tally_and_finish();
        end
        expPos = expPos + st;
        check(position, expPos);
        check(stepCount, mag(st));
        check(pulseTotal - n0, mag(st));
        check(motionState, MOTION_STOP);
        check(first, (mag(st) == 17'h1) ? MOTION_DECEL : MOTION_ACCEL);
        check(sawRun, expRun);
        check(drive.coils, coil_pat(drive.phaseIdx, hs));
        if (mag(st) == 17'h1) check(lead == int'(`ONE_STEP_DELAY) || lead == int'(`ONE_STEP_DELAY) + 1, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        seed = 32'd20547;
        rst_n = 1'b0;
        moveStart = 1'b0;
        halfStep = 1'b0;
        profile = '0;
        expPos = 0;
        n_mismatch = 0;
        checked = 0;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        moveStart = 1'b1;
        @(negedge clock);
        moveStart = 1'b0;
        check(moveBusy, 1'b0);
        do_move(17'sd1, 16'h7D00, 16'h4E20, 1'b0, 1'b0);
        do_move(-17'sd4, 16'h7D00, 16'h01F4, 1'b1, 1'b1);
        r = xs();
        do_move(r[0] ? -17'sd2 : 17'sd2, 16'(24000 + xs() % 8001), 16'h4E20, r[1], 1'b0);
        check(gapShort, 0);
        tally_and_finish();
    end
endmodule // tb
